// ### logic/cap_sense_accumulate_scan.sv
/*
  Digital control of a capacitive-sense converter: APB register file, discharge and
  conversion sequencing, accumulate and divide, threshold compare, auto-scan and
  interrupt. Assumes an analog front end that charges while fe_charge is high and
  presents a 16-bit code, asynchronous to sys_clk, by the end of the charge phase.
*/
// Design decision made here: register access over APB.
`timescale 1ns/100ps
module cap_sense_accumulate_scan
  import cap_sense_pkg::*;
#(
  parameter int CH_W = 5,
  parameter int CS_DIV = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog front end
  input wire logic [CODE_W-1:0] fe_code,
  output logic fe_discharge,
  output logic fe_charge,
  output logic [CH_W-1:0] fe_channel,
  output logic [2:0] fe_current_scale,
  // Interrupt
  output logic irq
);

  function automatic logic [2:0] acc_shift(input logic [2:0] sel);
    case (sel)
      3'h0: acc_shift = 3'h0;
      3'h1: acc_shift = 3'h2;
      3'h2: acc_shift = 3'h3;
      3'h3: acc_shift = 3'h4;
      3'h4: acc_shift = 3'h5;
      default: acc_shift = 3'h6;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] dt_cycles(input logic [2:0] code);
    case (code)
      3'h0: dt_cycles = CNT_W'(DT0_CYC);
      3'h1: dt_cycles = CNT_W'(DT1_CYC);
      3'h2: dt_cycles = CNT_W'(DT2_CYC);
      3'h3: dt_cycles = CNT_W'(DT3_CYC);
      3'h4: dt_cycles = CNT_W'(DT4_CYC);
      3'h5: dt_cycles = CNT_W'(DT5_CYC);
      default: dt_cycles = CNT_W'(DT7_CYC);
    endcase
  endfunction

  function automatic logic [4:0] conv_clocks(input logic [1:0] rate);
    case (rate)
      2'h0: conv_clocks = 5'(CONV_CLK_12);
      2'h1: conv_clocks = 5'(CONV_CLK_13);
      2'h2: conv_clocks = 5'(CONV_CLK_14);
      default: conv_clocks = 5'(CONV_CLK_16);
    endcase
  endfunction

  conv_state_t state_q, state_d;
  logic [7:0] mode_two_q, mode_two_d;
  logic auto_scan_q, auto_scan_d;
  logic [2:0] acc_sel_q, acc_sel_d;
  logic [15:0] result_q, result_d;
  logic [15:0] thresh_q, thresh_d;
  logic [CH_W-1:0] chan_q, chan_d;
  logic [CH_W-1:0] scan_start_q, scan_start_d;
  logic [CH_W-1:0] scan_end_q, scan_end_d;
  logic [ST_W-1:0] status_q, status_d;
  logic [ST_W-1:0] mask_q, mask_d;
  logic [ACC_W-1:0] acc_q, acc_d;
  logic [6:0] samp_q, samp_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [7:0] div_q, div_d;
  logic [CODE_W-1:0] code_meta_q, code_sync_q;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic irq_q, irq_d;

  logic [7:0] idx;
  logic mapped;
  logic wr_go;
  logic rd_go;
  logic cs_en;
  logic [1:0] rate;
  logic [4:0] res_bits;
  logic [CODE_W-1:0] sample;
  logic [ACC_W-1:0] sum;
  logic [6:0] count_target;
  logic [ST_W-1:0] events;
  logic [31:0] rd_val;
  logic [CH_W-1:0] chan_next;

  assign idx = paddr[9:2];
  assign rate = mode_two_q[MD2_RATE_LSB +: 2];
  assign res_bits = conv_clocks(rate);

  always_comb begin
    state_d = state_q;
    mode_two_d = mode_two_q;
    auto_scan_d = auto_scan_q;
    acc_sel_d = acc_sel_q;
    result_d = result_q;
    thresh_d = thresh_q;
    chan_d = chan_q;
    scan_start_d = scan_start_q;
    scan_end_d = scan_end_q;
    mask_d = mask_q;
    acc_d = acc_q;
    samp_d = samp_q;
    cnt_d = cnt_q;
    events = '0;
    // Converter clock enable
    cs_en = (div_q == 8'(CS_DIV - 1));
    div_d = cs_en ? 8'h00 : div_q + 8'h01;
    mapped = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) &&
             ((idx <= IDX_MASK) || (idx == IDX_MODE_TWO));
    // One wait state: pready rises in the second access cycle
    pready_d = psel && penable && !pready_q;
    pslverr_d = psel && penable && !pready_q && !mapped;
    wr_go = psel && penable && pready_q && pwrite && mapped;
    rd_go = psel && penable && pready_q && !pwrite && mapped;
    rd_val = '0;
    case (idx)
      IDX_CONTROL: begin
        rd_val[CTL_AUTO_SCAN] = auto_scan_q;
        rd_val[CTL_ACC_LSB +: 3] = acc_sel_q;
        rd_val[CTL_BUSY] = (state_q != S_IDLE);
      end
      IDX_RESULT: rd_val[15:0] = result_q;
      IDX_THRESHOLD: rd_val[15:0] = thresh_q;
      IDX_CHANNEL: rd_val[CH_W-1:0] = chan_q;
      IDX_SCAN: begin
        rd_val[SCAN_START_LSB +: CH_W] = scan_start_q;
        rd_val[SCAN_END_LSB +: CH_W] = scan_end_q;
      end
      IDX_STATUS: rd_val[ST_W-1:0] = status_q;
      IDX_MASK: rd_val[ST_W-1:0] = mask_q;
      IDX_MODE_TWO: rd_val[7:0] = mode_two_q;
      default: rd_val = '0;
    endcase
    prdata_d = (psel && penable && !pready_q && mapped) ? rd_val : prdata_q;
    // Only the synchronised copy of the asynchronous code is read
    sample = code_sync_q >> (5'd16 - res_bits);
    sum = acc_q + ACC_W'(sample);
    count_target = 7'(7'h01 << acc_shift(acc_sel_q));
    chan_next = (chan_q == scan_end_q) ? scan_start_q : chan_q + CH_W'(1);
    // Conversion sequencer
    case (state_q)
      S_IDLE: begin
        if (wr_go && idx == IDX_CONTROL && pwdata[CTL_START]) begin
          state_d = S_DISCHARGE;
          cnt_d = dt_cycles(mode_two_q[MD2_DT_LSB +: 3]);
          acc_d = '0;
          samp_d = '0;
        end
      end
      S_DISCHARGE: begin
        if (cnt_q <= CNT_W'(1)) begin
          state_d = S_CONVERT;
          cnt_d = CNT_W'(res_bits);
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      S_CONVERT: begin
        if (cs_en) begin
          if (cnt_q <= CNT_W'(1)) begin
            acc_d = sum;
            samp_d = samp_q + 7'h01;
            if (samp_q + 7'h01 == count_target) begin
              state_d = S_FINISH;
            end else begin
              state_d = S_DISCHARGE;
              cnt_d = dt_cycles(mode_two_q[MD2_DT_LSB +: 3]);
            end
          end else begin
            cnt_d = cnt_q - CNT_W'(1);
          end
        end
      end
      S_FINISH: begin
        result_d = 16'(acc_q >> acc_shift(acc_sel_q));
        acc_d = '0;
        samp_d = '0;
        events[ST_COMPLETE] = 1'b1;
        events[ST_GREATER] = (16'(acc_q >> acc_shift(acc_sel_q)) > thresh_q);
        if (auto_scan_q && !events[ST_GREATER]) begin
          chan_d = chan_next;
          state_d = S_DISCHARGE;
          cnt_d = dt_cycles(mode_two_q[MD2_DT_LSB +: 3]);
        end else begin
          state_d = S_IDLE;
        end
      end
      default: state_d = S_IDLE;
    endcase
    // Register writes; the channel setting holds while converting, the scan settings do not
    if (wr_go) begin
      case (idx)
        IDX_CONTROL: begin
          auto_scan_d = pwdata[CTL_AUTO_SCAN];
          acc_sel_d = pwdata[CTL_ACC_LSB +: 3];
        end
        IDX_THRESHOLD: thresh_d = pwdata[15:0];
        IDX_CHANNEL: begin
          if (state_q == S_IDLE) begin
            chan_d = pwdata[CH_W-1:0];
          end
        end
        IDX_SCAN: begin
          scan_start_d = pwdata[SCAN_START_LSB +: CH_W];
          scan_end_d = pwdata[SCAN_END_LSB +: CH_W];
        end
        IDX_MASK: mask_d = pwdata[ST_W-1:0];
        IDX_MODE_TWO: mode_two_d = pwdata[7:0];
        default: mode_two_d = mode_two_q;
      endcase
    end
    // Read clears status; a new event in the same cycle wins
    status_d = ((rd_go && idx == IDX_STATUS) ? '0 : status_q) | events;
    irq_d = |(status_d & mask_d);
  end

  always_ff @(posedge sys_clk) begin
    code_meta_q <= fe_code;
    code_sync_q <= code_meta_q;
    if (!rst_n) begin
      state_q <= S_IDLE;
      mode_two_q <= MODE_TWO_RESET;
      auto_scan_q <= 1'b0;
      acc_sel_q <= 3'h0;
      result_q <= 16'h0000;
      thresh_q <= 16'h0000;
      chan_q <= '0;
      scan_start_q <= '0;
      scan_end_q <= '0;
      status_q <= '0;
      mask_q <= '0;
      acc_q <= '0;
      samp_q <= 7'h00;
      cnt_q <= '0;
      div_q <= 8'h00;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_two_q <= mode_two_d;
      auto_scan_q <= auto_scan_d;
      acc_sel_q <= acc_sel_d;
      result_q <= result_d;
      thresh_q <= thresh_d;
      chan_q <= chan_d;
      scan_start_q <= scan_start_d;
      scan_end_q <= scan_end_d;
      status_q <= status_d;
      mask_q <= mask_d;
      acc_q <= acc_d;
      samp_q <= samp_d;
      cnt_q <= cnt_d;
      div_q <= div_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q <= irq_d;
    end
  end

  // Front-end drive, all from flip-flops
  logic fe_dis_q, fe_chg_q;
  logic [CH_W-1:0] fe_chan_q;
  logic [2:0] fe_ia_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fe_dis_q <= 1'b0;
      fe_chg_q <= 1'b0;
      fe_chan_q <= '0;
      fe_ia_q <= 3'h0;
    end else begin
      fe_dis_q <= (state_d == S_DISCHARGE);
      fe_chg_q <= (state_d == S_CONVERT);
      fe_chan_q <= chan_d;
      fe_ia_q <= mode_two_d[MD2_IA_LSB +: 3];
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign fe_discharge = fe_dis_q;
  assign fe_charge = fe_chg_q;
  assign fe_channel = fe_chan_q;
  assign fe_current_scale = fe_ia_q;
  assign irq = irq_q;
endmodule

// ### include/cap_sense_pkg.sv
/*
  Constants for the capacitive-sense accumulate and scan block: register indices,
  field positions, reset values and timing counts. Assumes a 100 MHz sys_clk.
*/
package cap_sense_pkg;
  // Register indices; the APB byte address is four times the index
  localparam logic [7:0] IDX_CONTROL = 8'h00;
  localparam logic [7:0] IDX_RESULT = 8'h01;
  localparam logic [7:0] IDX_THRESHOLD = 8'h02;
  localparam logic [7:0] IDX_CHANNEL = 8'h03;
  localparam logic [7:0] IDX_SCAN = 8'h04;
  localparam logic [7:0] IDX_STATUS = 8'h05;
  localparam logic [7:0] IDX_MASK = 8'h06;
  localparam logic [7:0] IDX_MODE_TWO = 8'hF3;
  // Control register fields
  localparam int CTL_START = 0;
  localparam int CTL_AUTO_SCAN = 1;
  localparam int CTL_ACC_LSB = 2;
  localparam int CTL_BUSY = 7;
  // Mode two register fields and reset value
  localparam int MD2_RATE_LSB = 6;
  localparam int MD2_DT_LSB = 3;
  localparam int MD2_IA_LSB = 0;
  localparam logic [7:0] MODE_TWO_RESET = 8'h40;
  // Scan register fields
  localparam int SCAN_START_LSB = 0;
  localparam int SCAN_END_LSB = 8;
  // Status and mask bits
  localparam int ST_COMPLETE = 0;
  localparam int ST_GREATER = 1;
  localparam int ST_W = 2;
  // Timing
  localparam int CLK_NS = 10;
  localparam int DT0_NS = 750;
  localparam int DT1_NS = 1000;
  localparam int DT2_NS = 1200;
  localparam int DT3_NS = 1500;
  localparam int DT4_NS = 2000;
  localparam int DT5_NS = 3000;
  localparam int DT7_NS = 6000;
  localparam int DT0_CYC = (DT0_NS + CLK_NS - 1) / CLK_NS;
  localparam int DT1_CYC = (DT1_NS + CLK_NS - 1) / CLK_NS;
  localparam int DT2_CYC = (DT2_NS + CLK_NS - 1) / CLK_NS;
  localparam int DT3_CYC = (DT3_NS + CLK_NS - 1) / CLK_NS;
  localparam int DT4_CYC = (DT4_NS + CLK_NS - 1) / CLK_NS;
  localparam int DT5_CYC = (DT5_NS + CLK_NS - 1) / CLK_NS;
  localparam int DT7_CYC = (DT7_NS + CLK_NS - 1) / CLK_NS;
  // Converter clocks per conversion for each rate code
  localparam int CONV_CLK_12 = 12;
  localparam int CONV_CLK_13 = 13;
  localparam int CONV_CLK_14 = 14;
  localparam int CONV_CLK_16 = 16;
  localparam int CODE_W = 16;
  localparam int ACC_W = 22;
  localparam int CNT_W = 10;

  typedef enum logic [1:0] {
    S_IDLE,
    S_DISCHARGE,
    S_CONVERT,
    S_FINISH
  } conv_state_t;
endpackage

// ### verification/fe_model.sv
/*
  Front-end stand-in: answers channel c with code {3'h0, c ^ 5'h01, 8'h34} while the
  sensor is driven, so that codes do not rise with the channel number.
  Assumes the block holds fe_channel steady from discharge to the end of charge.
*/
`timescale 1ns/100ps
module fe_model (
  // Block side
  input wire logic sys_clk,
  input wire logic fe_discharge,
  input wire logic fe_charge,
  input wire logic [4:0] fe_channel,
  // Sensor code
  output logic [15:0] fe_code
);
  logic [15:0] code_q = 16'h0000;
  logic [15:0] code_d;
  // Outside a conversion the code is not valid, so it toggles every cycle
  always_comb begin
    code_d = (fe_charge || fe_discharge) ? {3'h0, fe_channel ^ 5'h01, 8'h34} : ~code_q;
  end
  always_ff @(posedge sys_clk) begin
    code_q <= code_d;
  end
  assign fe_code = code_q;
endmodule

// ### verification/cap_sense_properties.sv
/*
  Port checker for the sense block, bound below.
  Assumes the synchronous active-low reset of sys_clk.
*/
`timescale 1ns/100ps
module cap_sense_properties
  import cap_sense_pkg::*;
#(
  parameter int CH_W = 5
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Front end and interrupt
  input wire logic fe_discharge,
  input wire logic fe_charge,
  input wire logic [CH_W-1:0] fe_channel,
  input wire logic [2:0] fe_current_scale,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  int dis_cnt_q;
  int dis_cnt_d;
  always_comb begin
    dis_cnt_d = (rst_n && fe_discharge) ? dis_cnt_q + 1 : 0;
  end
  always_ff @(posedge sys_clk) begin
    dis_cnt_q <= dis_cnt_d;
  end
  sequence apb_wait;
    psel && penable && !pready;
  endsequence
  sequence sensing;
    fe_charge || fe_discharge;
  endsequence
  a_ready_waits: assert property (apb_wait |=> pready) else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_error_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  a_phase_apart: assert property (!(fe_charge && fe_discharge)) else $error("phase overlap");
  a_discharge_first: assert property ($rose(fe_charge) |-> $past(fe_discharge))
    else $error("charge without discharge");
  a_discharge_span: assert property ($past(rst_n) && $fell(fe_discharge) |->
    dis_cnt_q >= DT0_CYC && dis_cnt_q <= DT7_CYC) else $error("discharge span");
  a_channel_held: assert property (sensing ##1 sensing |-> $stable(fe_channel))
    else $error("channel moved mid sample");
  a_scale_held: assert property (fe_charge |-> $stable(fe_current_scale))
    else $error("scale moved mid charge");
  a_reset_quiet: assert property (!$past(rst_n) |-> !irq && !fe_charge && !pready)
    else $error("outputs active after reset");
endmodule

bind cap_sense_accumulate_scan cap_sense_properties #(.CH_W(CH_W)) u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .fe_discharge(fe_discharge), .fe_charge(fe_charge),
  .fe_channel(fe_channel), .fe_current_scale(fe_current_scale), .irq(irq));

// ### verification/test_cap_sense_accumulate_scan.sv
/*
  Self-checking bench: register table rows, then single and scanning conversions.
  Assumes the front-end model answers channel c with code {3'h0, c ^ 5'h01, 8'h34}.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module test_cap_sense_accumulate_scan;
  import cap_sense_pkg::*;
  typedef struct {logic [7:0] idx; logic [31:0] wr; logic [31:0] exp; logic err;} row_t;
  logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic fe_discharge, fe_charge, irq;
  logic [15:0] fe_code;
  logic [4:0] fe_channel;
  logic [2:0] fe_current_scale;
  int error_cnt = 0, cmp_count = 0;
  row_t rows[6] = '{'{IDX_THRESHOLD, 32'hABCD1234, 32'h1234, 0},
    '{IDX_MASK, 32'hFF, 32'h3, 0}, '{IDX_SCAN, 32'hFFFF, 32'h1F1F, 0},
    '{IDX_CHANNEL, 32'h7, 32'h7, 0}, '{IDX_MODE_TWO, 32'h1C5, 32'hC5, 0},
    '{8'h40, 32'h5, 32'h0, 1}};
  cap_sense_accumulate_scan uut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fe_code(fe_code), .fe_discharge(fe_discharge),
    .fe_charge(fe_charge), .fe_channel(fe_channel), .fe_current_scale(fe_current_scale),
    .irq(irq));
  fe_model u_fe (.sys_clk(sys_clk), .fe_discharge(fe_discharge), .fe_charge(fe_charge),
    .fe_channel(fe_channel), .fe_code(fe_code));
  always #5 sys_clk = ~sys_clk;
  task automatic apb(input logic [7:0] idx, input logic wr, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    // Look between edges, so the value seen is the one the next rising edge samples
    @(negedge sys_clk);
    while (pready !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 50) error_cnt++;
    rd = prdata;
    err = pslverr;
    @(posedge sys_clk);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 3000) error_cnt++;
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1;
    apb(IDX_MODE_TWO, 0, 0);
    `CHK(rd, 32'h40)
    foreach (rows[i]) begin
      apb(rows[i].idx, 1, rows[i].wr);
      apb(rows[i].idx, 0, 0);
      `CHK(err, rows[i].err)
      if (!rows[i].err) `CHK(rd, rows[i].exp)
    end
    `CHK(fe_current_scale, 3'h5)
    $display("register table done");
    // Four samples on channel 2, nothing above a full-scale threshold
    apb(IDX_CHANNEL, 1, 32'h2);
    apb(IDX_THRESHOLD, 1, 32'hFFFF);
    apb(IDX_MASK, 1, 32'h1);
    apb(IDX_CONTROL, 1, 32'h5);
    wait_irq();
    apb(IDX_STATUS, 0, 0);
    `CHK(rd, 32'h1)
    apb(IDX_RESULT, 0, 0);
    `CHK(rd, 32'h0334)
    apb(IDX_CHANNEL, 0, 0);
    `CHK(rd, 32'h2)
    $display("accumulate test done");
    // Scan 3 (equal, not above) -> wrap to 1 (below) -> 2 above stops the scan
    apb(IDX_SCAN, 1, 32'h0301);
    apb(IDX_CHANNEL, 1, 32'h3);
    apb(IDX_THRESHOLD, 1, 32'h0234);
    apb(IDX_MASK, 1, 32'h2);
    apb(IDX_CONTROL, 1, 32'h3);
    wait_irq();
    apb(IDX_CHANNEL, 0, 0);
    `CHK(rd, 32'h2)
    apb(IDX_RESULT, 0, 0);
    `CHK(rd, 32'h0334)
    apb(IDX_STATUS, 0, 0);
    `CHK(rd, 32'h3)
    repeat (300) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    `CHK(fe_discharge, 1'b0)
    `CHK(fe_channel, 5'h02)
    $display("scan test done");
    // Reset in mid-conversion brings the mode register back to its default
    apb(IDX_MODE_TWO, 1, 32'h0);
    apb(IDX_CONTROL, 1, 32'h1);
    repeat (20) @(posedge sys_clk);
    rst_n <= 0;
    repeat (3) @(posedge sys_clk);
    `CHK(fe_discharge, 1'b0)
    rst_n <= 1;
    apb(IDX_MODE_TWO, 0, 0);
    `CHK(rd, 32'h40)
    apb(IDX_CONTROL, 0, 0);
    `CHK(rd, 32'h0)
    $display("reset test done");
    // Eight samples at rate 00 with discharge code 001, result above threshold
    apb(IDX_MODE_TWO, 1, 32'h08);
    apb(IDX_CHANNEL, 1, 32'h2);
    apb(IDX_THRESHOLD, 1, 32'h0010);
    apb(IDX_MASK, 1, 32'h3);
    apb(IDX_CONTROL, 1, 32'h9);
    wait_irq();
    apb(IDX_STATUS, 0, 0);
    `CHK(rd, 32'h3)
    apb(IDX_RESULT, 0, 0);
    `CHK(rd, 32'h0033)
    apb(IDX_CHANNEL, 0, 0);
    `CHK(rd, 32'h2)
    `CHK(fe_current_scale, 3'h0)
    $display("rate test done");
    complete_run();
  end
endmodule
